// file: core/lgp_pkg.sv
// Shared constants for the LED grayscale PWM serial port core
package lgp_pkg;

    // Channel geometry
    localparam int LGP_CHANNELS = 16;
    localparam int LGP_GS_BITS  = 16;
    localparam int LGP_BC_BITS  = 7;

    // Register byte offsets
    localparam logic [7:0] LGP_OFS_CTRL     = 8'h00;
    localparam logic [7:0] LGP_OFS_STATUS   = 8'h04;
    localparam logic [7:0] LGP_OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] LGP_OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] LGP_OFS_BC       = 8'h10;
    localparam logic [7:0] LGP_OFS_COUNT    = 8'h14;

    // Control register fields
    localparam int LGP_CTRL_BLANK_BIT = 0;

    // Status register fields
    localparam int LGP_STAT_OPEN_BIT  = 0;
    localparam int LGP_STAT_TEMP_BIT  = 1;
    localparam int LGP_STAT_BLANK_BIT = 2;
    localparam int LGP_STAT_STATE_LSB = 4;

    // Interrupt status and mask fields
    localparam int LGP_IRQ_W        = 4;
    localparam int LGP_IRQ_GS_LATCH = 0;
    localparam int LGP_IRQ_BC_LATCH = 1;
    localparam int LGP_IRQ_FAULT    = 2;
    localparam int LGP_IRQ_PWM_DONE = 3;

    // Values after reset
    localparam logic                 LGP_CTRL_BLANK_RST = 1'h0;
    localparam logic [LGP_IRQ_W-1:0] LGP_IRQ_MASK_RST   = 4'h0;

    // Positions of the synchronised pins
    localparam int LGP_PINS     = 8;
    localparam int LGP_PIN_SIN  = 0;
    localparam int LGP_PIN_SCK  = 1;
    localparam int LGP_PIN_LAT  = 2;
    localparam int LGP_PIN_BANK = 3;
    localparam int LGP_PIN_PWM  = 4;
    localparam int LGP_PIN_OFF  = 5;
    localparam int LGP_PIN_OPEN = 6;
    localparam int LGP_PIN_TEMP = 7;

    // PWM timing controller states
    typedef enum logic [1:0] {
        LGP_PWM_IDLE = 2'b00,
        LGP_PWM_RUN  = 2'b01,
        LGP_PWM_DONE = 2'b10
    } lgp_pwm_state_t;

endpackage : lgp_pkg

// file: core/lgp_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module lgp_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // Pins and synchronised levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : lgp_sync
`default_nettype wire

// file: core/lgp_top.sv
// LED grayscale PWM core: serial shift port, latches, PWM counter, errors, APB
`timescale 1ns/1ps
`default_nettype none
// Function
// - Each shift clock rising edge captures serial_in into the selected register.
// - Each shift clock rising edge moves the selected register one bit toward MSB.
// - serial_out shows the MSB of the register chosen by bank_select.
// - A latch strobe rising edge copies the chosen shift register into its latch.
// - bank_select low routes shifting and latching to the gray-level register.
// - bank_select high routes shifting and latching to the brightness register.
// - Without force-off or the control blank bit, each PWM reference rising edge advances the counter by one until it reaches all ones, then it holds.
// - Force-off turns all sinks off, holds counter zero, restarts PWM control.
// - Without force-off or the control blank bit, the PWM controller decides each sink's on/off state.
// - Open-drain error output pulled low while an open LED or overtemperature shows.
module lgp_top
    import lgp_pkg::*;
#(
    parameter int CHANNELS = LGP_CHANNELS,
    parameter int GS_BITS  = LGP_GS_BITS,
    parameter int BC_BITS  = LGP_BC_BITS
) (
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                resetn_in,
    // Serial port pins
    input  wire logic                serial_in,
    input  wire logic                shift_clock_in,
    input  wire logic                latch_strobe_in,
    input  wire logic                bank_select_in,
    output var  logic                serial_out,
    // PWM control pins
    input  wire logic                pwm_ref_clock_in,
    input  wire logic                force_all_off_in,
    output var  logic [CHANNELS-1:0] sink_output_out,
    output var  logic [BC_BITS-1:0]  brightness_code_out,
    // Fault detector inputs and open-drain error pin
    input  wire logic                open_led_detect_in,
    input  wire logic                overtemp_flag_in,
    output var  logic                error_n_out,
    output var  logic                error_n_oe_out,
    // APB slave
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [7:0]          paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output var  logic [31:0]         prdata_out,
    output var  logic                pready_out,
    output var  logic                pslverr_out,
    // Interrupt
    output var  logic                irq_out
);
    localparam int GS_TOTAL = CHANNELS * GS_BITS;

    logic [LGP_PINS-1:0]  pin_s;
    logic [LGP_PINS-1:0]  pin_prev_reg;
    logic                 sck_rise;
    logic                 lat_rise;
    logic                 pwm_rise;
    logic                 bank_s;
    logic                 sin_s;
    logic                 fault;
    logic                 blank;
    logic [GS_TOTAL-1:0]  gs_shift_reg;
    logic [BC_BITS-1:0]   bc_shift_reg;
    logic [GS_TOTAL-1:0]  gs_latch_reg;
    logic [BC_BITS-1:0]   bc_latch_reg;
    logic [GS_BITS-1:0]   count_reg;
    lgp_pwm_state_t       state_reg;
    logic [CHANNELS-1:0]  sink_next;
    logic                 ctrl_blank_reg;
    logic [LGP_IRQ_W-1:0] irq_stat_reg;
    logic [LGP_IRQ_W-1:0] irq_mask_reg;
    logic [LGP_IRQ_W-1:0] irq_set;
    logic [LGP_IRQ_W-1:0] irq_clr;
    logic                 fault_prev_reg;
    logic                 pwm_wrap;
    logic                 apb_access;
    logic                 apb_write;
    logic                 addr_ok;
    logic [31:0]          rd_mux;

    // Pins cross into the core clock
    lgp_sync #(
        .WIDTH(LGP_PINS)
    ) u_sync (
        .clk_in   (clk_in),
        .resetn_in(resetn_in),
        .async_in ({overtemp_flag_in, open_led_detect_in, force_all_off_in,
                    pwm_ref_clock_in, bank_select_in, latch_strobe_in,
                    shift_clock_in, serial_in}),
        .sync_out (pin_s)
    );

    // Previous synchronised levels for edge finding
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            pin_prev_reg <= '0;
        else
            pin_prev_reg <= pin_s;
    end

    // Edges and levels of the link
    assign sck_rise = pin_s[LGP_PIN_SCK] & ~pin_prev_reg[LGP_PIN_SCK];
    assign lat_rise = pin_s[LGP_PIN_LAT] & ~pin_prev_reg[LGP_PIN_LAT];
    assign pwm_rise = pin_s[LGP_PIN_PWM] & ~pin_prev_reg[LGP_PIN_PWM];
    assign bank_s   = pin_s[LGP_PIN_BANK];
    assign sin_s    = pin_s[LGP_PIN_SIN];
    assign fault    = pin_s[LGP_PIN_OPEN] | pin_s[LGP_PIN_TEMP];
    assign blank    = pin_s[LGP_PIN_OFF] | ctrl_blank_reg;

    // Gray-level shift register, serial_in enters at bit 0
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            gs_shift_reg <= '0;
        else if (sck_rise && !bank_s)
            gs_shift_reg <= {gs_shift_reg[GS_TOTAL-2:0], sin_s};
    end

    // Brightness shift register
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            bc_shift_reg <= '0;
        else if (sck_rise && bank_s)
            bc_shift_reg <= {bc_shift_reg[BC_BITS-2:0], sin_s};
    end

    // Daisy-chain output from the selected MSB
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            serial_out <= 1'b0;
        else
            serial_out <= bank_s ? bc_shift_reg[BC_BITS-1] : gs_shift_reg[GS_TOTAL-1];
    end

    // First data latches
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            gs_latch_reg <= '0;
            bc_latch_reg <= '0;
        end
        else if (lat_rise)
        begin
            if (bank_s)
                bc_latch_reg <= bc_shift_reg;
            else
                gs_latch_reg <= gs_shift_reg;
        end
    end

    assign brightness_code_out = bc_latch_reg;

    // Sink levels one count ahead, one comparator per channel
    for (genvar i = 0; i < CHANNELS; i++)
    begin : g_sink
        assign sink_next[i] = (state_reg == LGP_PWM_IDLE)
            ? (gs_latch_reg[i*GS_BITS +: GS_BITS] != '0)
            : ((count_reg + GS_BITS'(1)) <= gs_latch_reg[i*GS_BITS +: GS_BITS]);
    end

    assign pwm_wrap = pwm_rise && (state_reg == LGP_PWM_RUN) && (count_reg == '1);

    // PWM timing controller and grayscale counter
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_reg       <= LGP_PWM_IDLE;
            count_reg       <= '0;
            sink_output_out <= '0;
        end
        else if (blank)
        begin
            state_reg       <= LGP_PWM_IDLE;
            count_reg       <= '0;
            sink_output_out <= '0;
        end
        else if (pwm_rise)
        begin
            unique case (state_reg)
                LGP_PWM_IDLE:
                begin
                    state_reg       <= LGP_PWM_RUN;
                    count_reg       <= count_reg + GS_BITS'(1);
                    sink_output_out <= sink_next;
                end
                LGP_PWM_RUN:
                begin
                    if (count_reg == '1)
                    begin
                        state_reg       <= LGP_PWM_DONE;
                        sink_output_out <= '0;
                    end
                    else
                    begin
                        count_reg       <= count_reg + GS_BITS'(1);
                        sink_output_out <= sink_next;
                    end
                end
                LGP_PWM_DONE: sink_output_out <= '0;
                default:
                begin
                    state_reg       <= LGP_PWM_IDLE;
                    count_reg       <= '0;
                    sink_output_out <= '0;
                end
            endcase
        end
    end

    // Open-drain error pin, pulled low on a fault
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            error_n_oe_out <= 1'b0;
        else
            error_n_oe_out <= fault;
    end

    assign error_n_out = 1'b0;

    // APB decode
    assign apb_access  = psel_in & penable_in & pready_out;
    assign apb_write   = apb_access & pwrite_in;
    assign addr_ok     = (paddr_in == LGP_OFS_CTRL) || (paddr_in == LGP_OFS_STATUS) ||
                         (paddr_in == LGP_OFS_IRQ_STAT) || (paddr_in == LGP_OFS_IRQ_MASK) ||
                         (paddr_in == LGP_OFS_BC) || (paddr_in == LGP_OFS_COUNT);

    // Read data selection
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr_in)
            LGP_OFS_CTRL:     rd_mux[LGP_CTRL_BLANK_BIT] = ctrl_blank_reg;
            LGP_OFS_STATUS:
            begin
                rd_mux[LGP_STAT_OPEN_BIT]                 = pin_s[LGP_PIN_OPEN];
                rd_mux[LGP_STAT_TEMP_BIT]                 = pin_s[LGP_PIN_TEMP];
                rd_mux[LGP_STAT_BLANK_BIT]                = blank;
                rd_mux[LGP_STAT_STATE_LSB +: 2]           = state_reg;
            end
            LGP_OFS_IRQ_STAT: rd_mux[LGP_IRQ_W-1:0]  = irq_stat_reg;
            LGP_OFS_IRQ_MASK: rd_mux[LGP_IRQ_W-1:0]  = irq_mask_reg;
            LGP_OFS_BC:       rd_mux[BC_BITS-1:0]    = bc_latch_reg;
            LGP_OFS_COUNT:    rd_mux[GS_BITS-1:0]    = count_reg;
            default:          rd_mux                 = 32'h0000_0000;
        endcase
    end

    // One wait state, then answer with registered data
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out  <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
            if (psel_in && penable_in && !pready_out && !pwrite_in)
                prdata_out <= rd_mux;
        end
    end

    // Control and mask registers
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ctrl_blank_reg <= LGP_CTRL_BLANK_RST;
            irq_mask_reg   <= LGP_IRQ_MASK_RST;
        end
        else if (apb_write)
        begin
            if (paddr_in == LGP_OFS_CTRL)
                ctrl_blank_reg <= pwdata_in[LGP_CTRL_BLANK_BIT];
            if (paddr_in == LGP_OFS_IRQ_MASK)
                irq_mask_reg <= pwdata_in[LGP_IRQ_W-1:0];
        end
    end

    // Fault rise detection for the event
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            fault_prev_reg <= 1'b0;
        else
            fault_prev_reg <= fault;
    end

    // Events and write-one-to-clear
    always_comb
    begin
        irq_set                   = '0;
        irq_set[LGP_IRQ_GS_LATCH] = lat_rise & ~bank_s;
        irq_set[LGP_IRQ_BC_LATCH] = lat_rise & bank_s;
        irq_set[LGP_IRQ_FAULT]    = fault & ~fault_prev_reg;
        irq_set[LGP_IRQ_PWM_DONE] = pwm_wrap & ~blank;
        irq_clr = (apb_write && paddr_in == LGP_OFS_IRQ_STAT) ? pwdata_in[LGP_IRQ_W-1:0] : '0;
    end

    // Sticky status, a new event beats a clear
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            irq_stat_reg <= '0;
        else
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end

    // Level interrupt
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end

    // Checks
    a_gs_shift_capture: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sck_rise && !bank_s) |=> (gs_shift_reg[0] == $past(sin_s)) &&
        (gs_shift_reg[GS_TOTAL-1:1] == $past(gs_shift_reg[GS_TOTAL-2:0])))
        else $error("gray-level shift did not capture or move");
    a_bc_shift_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!sck_rise || !bank_s) |=> $stable(bc_shift_reg))
        else $error("brightness shift register moved while not selected");
    a_bc_shift_move: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sck_rise && bank_s) |=> (bc_shift_reg == {$past(bc_shift_reg[BC_BITS-2:0]), $past(sin_s)}))
        else $error("brightness shift did not move one bit");
    a_serial_out_msb: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ##1 serial_out == ($past(bank_s) ? $past(bc_shift_reg[BC_BITS-1])
                                         : $past(gs_shift_reg[GS_TOTAL-1])))
        else $error("serial_out is not the selected MSB");
    a_latch_copy_bank: assert property (@(posedge clk_in) disable iff (!resetn_in)
        lat_rise |=> ($past(bank_s) ? (bc_latch_reg == $past(bc_shift_reg))
                                    : (gs_latch_reg == $past(gs_shift_reg))))
        else $error("latch strobe did not copy the selected register");
    a_count_advance: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (pwm_rise && !blank && state_reg != LGP_PWM_DONE && count_reg != '1)
        |=> count_reg == $past(count_reg) + GS_BITS'(1))
        else $error("grayscale counter did not advance");
    a_blank_forces_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
        blank |=> (sink_output_out == '0) && (count_reg == '0) && (state_reg == LGP_PWM_IDLE))
        else $error("force-off did not clear outputs and counter");
    a_sink_on_time: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (pwm_rise && !blank && state_reg == LGP_PWM_RUN && count_reg != '1)
        |=> sink_output_out[0] == (count_reg <= gs_latch_reg[GS_BITS-1:0]))
        else $error("channel zero on-time does not match its gray level");
    a_error_pin_drive: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ##1 (error_n_oe_out == $past(fault)) && (error_n_out == 1'b0))
        else $error("error pin does not follow the fault inputs");
endmodule : lgp_top
`default_nettype wire

// file: verif/lgp_ctl_model.sv
// Display controller model driving the serial link, strobe, PWM clock and blank
`timescale 1ns/1ps
`default_nettype none
module lgp_ctl_model (
    // Core clock used as time base
    input  wire logic clk_in,
    // Pins toward the core
    output var  logic serial_in,
    output var  logic shift_clock,
    output var  logic latch_strobe,
    output var  logic bank_select,
    output var  logic pwm_ref_clock,
    output var  logic force_all_off
);
    // Idle levels, blank asserted until the first frame
    initial
    begin
        serial_in     = 1'h0;
        shift_clock   = 1'h0;
        latch_strobe  = 1'h0;
        bank_select   = 1'h0;
        pwm_ref_clock = 1'h0;
        force_all_off = 1'h1;
    end

    // Half of the 80 ns link period
    task automatic half();
        repeat (4) @(posedge clk_in);
    endtask : half

    // Bank change only while the shift clock is low
    task automatic set_bank(input logic v);
        bank_select <= v;
        half();
        half();
    endtask : set_bank

    // Shift n bits MSB first; data line shows the inverse once released
    task automatic shift_bits(input logic bank, input logic [255:0] data, input int n);
        set_bank(bank);
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in   <= data[i];
            half();
            shift_clock <= 1'h1;
            half();
            shift_clock <= 1'h0;
        end
        serial_in <= ~data[0];
        half();
    endtask : shift_bits

    // One latch strobe pulse
    task automatic latch();
        latch_strobe <= 1'h1;
        half();
        latch_strobe <= 1'h0;
        half();
    endtask : latch

    // Reference clock pulses, then the clock stands low
    task automatic pwm(input int n);
        repeat (n)
        begin
            pwm_ref_clock <= 1'h1;
            half();
            pwm_ref_clock <= 1'h0;
            half();
        end
    endtask : pwm

    // Blank level
    task automatic blank(input logic v);
        force_all_off <= v;
        half();
    endtask : blank
endmodule : lgp_ctl_model
`default_nettype wire

// file: verif/lgp_top_tb.sv
// Self-checking bench for the LED grayscale PWM core
`timescale 1ns/1ps
`default_nettype none
module lgp_top_tb
    import lgp_pkg::*;
;
    logic        clk_in;
    logic        resetn_in;
    logic        serial_in, shift_clock, latch_strobe, bank_select, pwm_ref_clock;
    logic        force_all_off;
    logic        open_led, overtemp;
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, serial_out, error_n, error_n_oe, irq;
    logic [15:0] sinks;
    logic [6:0]  bright;
    logic [31:0] rd;
    logic        err;
    logic [255:0] gray;
    logic [15:0] exp_sink [1:4];
    int          error_cnt = 0;
    int          checked   = 0;

    // Core clock, 100 MHz
    initial
    begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end

    lgp_ctl_model u_ctl (
        .clk_in       (clk_in),
        .serial_in    (serial_in),
        .shift_clock  (shift_clock),
        .latch_strobe (latch_strobe),
        .bank_select  (bank_select),
        .pwm_ref_clock(pwm_ref_clock),
        .force_all_off(force_all_off)
    );

    lgp_top u_dut (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .serial_in(serial_in), .shift_clock_in(shift_clock),
        .latch_strobe_in(latch_strobe), .bank_select_in(bank_select),
        .serial_out(serial_out), .pwm_ref_clock_in(pwm_ref_clock),
        .force_all_off_in(force_all_off), .sink_output_out(sinks),
        .brightness_code_out(bright), .open_led_detect_in(open_led),
        .overtemp_flag_in(overtemp), .error_n_out(error_n), .error_n_oe_out(error_n_oe),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .irq_out(irq)
    );

    // Verdict and end of run
    task automatic wrap_up();
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // Value comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, waiting for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_in);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_in);
        penable <= 1'h1;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        if (n >= 50)
            error_cnt++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Fault pins and wait for the synchronised result
    task automatic faults(input logic o, input logic t);
        @(posedge clk_in);
        open_led <= o;
        overtemp <= t;
        repeat (8) @(posedge clk_in);
    endtask : faults

    // Watchdog
    initial
    begin
        #500us;
        error_cnt++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        resetn_in = 1'h0;
        {psel, penable, pwrite, open_led, overtemp} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge clk_in);
        resetn_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        // Reset values and an unmapped address
        apb(1'h0, LGP_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, LGP_OFS_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // Brightness bank: 7 bits, MSB first
        u_ctl.shift_bits(1'h1, 256'h25, 7);
        chk({31'h0, serial_out}, 32'h0);
        u_ctl.latch();
        chk({25'h0, bright}, 32'h25);
        // Interrupt: sticky, masked, then cleared
        apb(1'h0, LGP_OFS_IRQ_STAT, 32'h0);
        chk(rd, 32'h2);
        chk({31'h0, irq}, 32'h0);
        apb(1'h1, LGP_OFS_IRQ_MASK, 32'h2);
        repeat (3) @(posedge clk_in);
        chk({31'h0, irq}, 32'h1);
        apb(1'h1, LGP_OFS_IRQ_STAT, 32'h2);
        repeat (3) @(posedge clk_in);
        chk({31'h0, irq}, 32'h0);
        // Gray bank: channel 0 = 3, channel 1 = 1, channel 15 = 8001
        gray = '0;
        gray[15:0] = 16'h0003;
        gray[31:16] = 16'h0001;
        gray[255:240] = 16'h8001;
        u_ctl.shift_bits(1'h0, gray, 256);
        chk({31'h0, serial_out}, 32'h1);
        chk({25'h0, bright}, 32'h25);
        u_ctl.set_bank(1'h1);
        chk({31'h0, serial_out}, 32'h0);
        u_ctl.set_bank(1'h0);
        chk({31'h0, serial_out}, 32'h1);
        u_ctl.latch();
        chk({16'h0, sinks}, 32'h0);
        // PWM frame after blank falls
        exp_sink[1] = 16'h8003;
        exp_sink[2] = 16'h8001;
        exp_sink[3] = 16'h8001;
        exp_sink[4] = 16'h8000;
        u_ctl.blank(1'h0);
        for (int k = 1; k <= 4; k++)
        begin
            u_ctl.pwm(1);
            chk({16'h0, sinks}, {16'h0, exp_sink[k]});
        end
        apb(1'h0, LGP_OFS_COUNT, 32'h0);
        chk(rd, 32'h4);
        apb(1'h0, LGP_OFS_STATUS, 32'h0);
        chk(rd, 32'h10);
        // Soft blank from the control register, then brightness read-back
        apb(1'h1, LGP_OFS_CTRL, 32'h1);
        apb(1'h0, LGP_OFS_STATUS, 32'h0);
        chk(rd, 32'h4);
        chk({16'h0, sinks}, 32'h0);
        apb(1'h0, LGP_OFS_BC, 32'h0);
        chk(rd, 32'h25);
        apb(1'h1, LGP_OFS_CTRL, 32'h0);
        u_ctl.blank(1'h1);
        chk({16'h0, sinks}, 32'h0);
        apb(1'h0, LGP_OFS_COUNT, 32'h0);
        chk(rd, 32'h0);
        // Error pin for each fault source
        for (int f = 0; f < 2; f++)
        begin
            faults(f == 0, f == 1);
            chk({30'h0, error_n_oe, error_n}, 32'h2);
            faults(1'h0, 1'h0);
            chk({31'h0, error_n_oe}, 32'h0);
        end
        apb(1'h0, LGP_OFS_IRQ_STAT, 32'h0);
        chk(rd, 32'h5);
        wrap_up();
    end
endmodule : lgp_top_tb
`default_nettype wire
